// *** test/aif_filter_cfg_properties.sv ***
// Timing checks on the ports of the filter configuration block
`default_nettype none
module aif_filter_cfg_chk
    import aif_pkg::*;
(
    input wire logic                   i_clk,       // Clock
    input wire logic                   i_rst_b,     // Reset, low
    input wire logic                   i_hsel,      // Select
    input wire logic [31:0]            i_haddr,     // Address
    input wire logic [1:0]             i_htrans,    // Transfer
    input wire logic                   i_hwrite,    // Write
    input wire logic [31:0]            i_hwdata,    // Write data
    input wire logic                   i_hready,    // Bus ready
    input wire logic [31:0]            o_hrdata,    // Read data
    input wire logic                   o_hreadyout, // Slave ready
    input wire logic                   o_hresp,     // Response
    input wire aif_sample_type [AIF_NUM_IO-1:0] i_ain, // Samples
    input wire logic [AIF_NUM_IO-1:0][AIF_SAMPLE_W-1:0] o_avg, // Avg
    input wire logic                   o_released   // Released
);
    logic       rd_q;
    logic       wc_q;
    logic       go_q;
    logic [5:0] idx_q;
    wire take = i_hsel & i_hready & (i_htrans == AIF_HTRANS_NSEQ);
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rd_q  <= 1'b0;
            wc_q  <= 1'b0;
            go_q  <= 1'b0;
            idx_q <= 6'h00;
        end
        else
        begin
            rd_q  <= take & !i_hwrite;
            wc_q  <= take & i_hwrite & (i_haddr[7:2] == AIF_IDX_CTRL);
            go_q  <= wc_q & i_hwdata[AIF_CTRL_GO];
            idx_q <= i_haddr[7:2];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_ready; o_hreadyout && o_hresp == AIF_HRESP_OKAY; endproperty
    a_ready: assert property (p_ready) else $error("bus not ready");
    property p_info; rd_q && idx_q == AIF_IDX_INFO |-> o_hrdata == 32'h201;
    endproperty
    a_info: assert property (p_info) else $error("bad id");
    property p_unmap; rd_q && idx_q > AIF_IDX_INFO |-> o_hrdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold; !rd_q |-> $stable(o_hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rel;
        wc_q && i_hwdata[AIF_CTRL_GO] |=> !o_released ##1 o_released;
    endproperty
    a_rel: assert property (p_rel) else $error("release late");
    property p_rise; $rose(o_released) |-> $past(go_q); endproperty
    a_rise: assert property (p_rise) else $error("stray release");
    property p_avg0; !i_ain[0].valid |=> $stable(o_avg[0]); endproperty
    a_avg0: assert property (p_avg0) else $error("avg0 moved");
    property p_avg1; $changed(o_avg[1]) |-> $past(i_ain[1].valid); endproperty
    a_avg1: assert property (p_avg1) else $error("avg1 moved");
endmodule
`default_nettype wire

// *** test/aif_sample_src.sv ***
// Analog sample source feeding one-cycle sample pulses
`default_nettype none
module aif_sample_src
    import aif_pkg::*;
(
    input wire logic                    i_clk,  // Clock
    input wire logic                    i_fire, // Send one sample
    input wire logic                    i_ch,   // Target input
    input wire logic [AIF_SAMPLE_W-1:0] i_val,  // Sample value
    output var aif_sample_type [AIF_NUM_IO-1:0] o_ain // Samples
);
    initial o_ain = '0;
    // Idle data toggles so a stale value is never mistaken for a sample
    always @(posedge i_clk)
        for (int c = 0; c < AIF_NUM_IO; c++)
            o_ain[c] <= (i_fire && i_ch == c) ? {1'b1, i_val}
                                              : {1'b0, ~o_ain[c].data};
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the filter configuration block
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aif_pkg::*;
    logic i_clk = 0, i_rst_b = 0, i_hsel = 0, i_hwrite = 0, fire = 0, ch = 0;
    logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
    logic [1:0] i_htrans = 0;
    logic [15:0] val = 0;
    logic o_hreadyout, o_hresp, o_released;
    aif_sample_type [AIF_NUM_IO-1:0] i_ain;
    logic [AIF_NUM_IO-1:0][AIF_SAMPLE_W-1:0] o_avg;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    aif_filter_cfg aif_filter_cfg_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
        .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_ain(i_ain),
        .o_avg(o_avg), .o_released(o_released));
    aif_sample_src aif_sample_src_inst (.i_clk(i_clk), .i_fire(fire),
        .i_ch(ch), .i_val(val), .o_ain(i_ain));
    task automatic results();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic bx(input logic w, input logic [5:0] ix,
        inout logic [31:0] d);
        i_hsel <= 1;
        i_haddr <= {24'h0, ix, 2'h0};
        i_htrans <= AIF_HTRANS_NSEQ;
        i_hwrite <= w;
        do @(posedge i_clk); while (!o_hreadyout);
        i_htrans <= 2'h0;
        i_hsel <= 0;
        i_hwdata <= d;
        do @(posedge i_clk); while (!o_hreadyout);
        if (!w) d = o_hrdata;
    endtask
    task automatic req(input logic [11:0] resource_identifier, input logic [14:0] off,
        input logic [31:0] b, c, output logic [31:0] st, res);
        logic [31:0] d;
        d = {20'h0, resource_identifier};
        bx(1, AIF_IDX_RID, d);
        d = {17'h0, off};
        bx(1, AIF_IDX_OFFSET, d);
        d = b;
        bx(1, AIF_IDX_BUFFER, d);
        d = c;
        bx(1, AIF_IDX_CTRL, d);
        st = 0;
        while (!st[AIF_CTRL_REL]) bx(0, AIF_IDX_CTRL, st);
        bx(0, AIF_IDX_RES_LO, res);
    endtask
    task automatic smp(input logic c, input logic [15:0] v, e);
        fire <= 1; ch <= c; val <= v;
        @(posedge i_clk);
        fire <= 0;
        repeat (3) @(posedge i_clk);
        `CHK(o_avg[c], e)
    endtask
    task automatic t_reset();
        logic [31:0] d;
        bx(0, AIF_IDX_FILT, d);
        `CHK(d, 32'h6464)
        bx(0, AIF_IDX_INFO, d);
        `CHK(d, 32'h201)
        bx(0, 6'h0a, d);
        `CHK(d, 32'h0)
    endtask
    task automatic t_def();
        logic [31:0] st, r, exp[6];
        exp = '{AIF_LABEL_LO, 32'h4, 32'h0, 32'h2, 32'h5a, 32'h14};
        for (int i = 0; i < 7; i++)
        begin
            req(12'h201, i[14:0], 32'h0, 32'h5, st, r);
            `CHK(st[AIF_CTRL_ERR], i == 6)
            if (i < 6) `CHK(r, exp[i])
            if (i == 0)
            begin
                bx(0, AIF_IDX_RES_HI, r);
                `CHK(r, AIF_LABEL_HI)
            end
        end
    endtask
    task automatic t_wr();
        logic [31:0] st, r, d, b[6], c[6];
        logic [14:0] o[6];
        logic [11:0] rd[6];
        b = '{0, 32'h65, 32'h32, 32'h32, 32'h32, 32'h32};
        o = '{0, 0, 2, 32767, 0, 0};
        c = '{32'h23, 32'h23, 32'h23, 32'h23, 32'h13, 32'h23};
        rd = '{12'h201, 12'h201, 12'h201, 12'h201, 12'h201, 12'h200};
        for (int i = 0; i < 6; i++)
        begin
            req(rd[i], o[i], b[i], c[i], st, r);
            `CHK(st[AIF_CTRL_ERR], 1'b1)
        end
        bx(0, AIF_IDX_FILT, d);
        `CHK(d, 32'h6464)
        req(12'h201, 0, 32'h32, 32'h23, st, r);
        `CHK(st[AIF_CTRL_ERR], 1'b0)
        req(12'h201, 1, 32'h1, 32'h23, st, r);
        `CHK(st[AIF_CTRL_ERR], 1'b0)
        bx(0, AIF_IDX_FILT, d);
        `CHK(d, 32'h0132)
        req(12'h201, 0, 32'h0, 32'h1, st, r);
        `CHK(r, 32'h32)
        req(12'h201, 1, 32'h0, 32'h1, st, r);
        `CHK(r, 32'h1)
    endtask
    task automatic t_filt();
        logic [31:0] st, r, d;
        smp(0, 16'd1000, 16'd1000);
        smp(0, 16'd2000, 16'd1500);
        smp(1, 16'd10000, 16'd10000);
        smp(1, 16'd0, 16'd9900);
        req(12'h201, 0, 32'h64, 32'h23, st, r);
        `CHK(o_released, 1'b1)
        smp(0, 16'd7, 16'd7);
        `CHK(o_avg[1], 16'd9900)
        bx(0, AIF_IDX_AVG0, d);
        `CHK(d, 32'h7)
        bx(0, AIF_IDX_AVG1, d);
        `CHK(d, 32'h26ac)
    endtask
    // Mid-run reset: outputs clear and filters fall back to pass-through
    task automatic t_rst();
        i_rst_b <= 0;
        @(posedge i_clk);
        `CHK(o_avg, 32'h0)
        `CHK(o_released, 1'b0)
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1;
        @(posedge i_clk);
        t_reset();
        smp(1, 16'h012c, 16'h012c);
        smp(1, 16'h01f4, 16'h01f4);
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1;
        @(posedge i_clk);
        t_reset();
        t_def();
        t_wr();
        t_filt();
        t_rst();
        results();
    end
endmodule
bind aif_filter_cfg aif_filter_cfg_chk chk_inst (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_ain(i_ain), .o_avg(o_avg),
    .o_released(o_released));
`default_nettype wire

// *** verilog/aif_filter_cfg.sv ***
// Parameter-channel handler and low-pass filter for two analog inputs
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`default_nettype none
module aif_filter_cfg
    import aif_pkg::*;
(
    input  wire logic                 i_clk,       // 100 MHz clock
    input  wire logic                 i_rst_b,     // Async reset, low
    input  wire logic                 i_hsel,      // AHB slave select
    input  wire logic [31:0]          i_haddr,     // AHB address
    input  wire logic [1:0]           i_htrans,    // AHB transfer type
    input  wire logic                 i_hwrite,    // AHB write
    input  wire logic [2:0]           i_hsize,     // AHB size
    input  wire logic [31:0]          i_hwdata,    // AHB write data
    input  wire logic                 i_hready,    // AHB bus ready
    output logic      [31:0]          o_hrdata,    // AHB read data
    output logic                      o_hreadyout, // AHB slave ready
    output logic                      o_hresp,     // AHB response
    input  wire aif_sample_type [AIF_NUM_IO-1:0] i_ain, // Raw samples
    output logic [AIF_NUM_IO-1:0][AIF_SAMPLE_W-1:0] o_avg, // Filtered
    output logic                      o_released   // Request released
);

    // ----------------------------------------------------------------
    // Register map, one word each, address bits 7:2 pick the word
    // ----------------------------------------------------------------
    // 00 resource select     rw  bits 11:0
    // 04 access offset       rw  bits 14:0
    // 08 message buffer      rw  byte 0 is the filter setting
    // 0c command control     w   0 go, 1 write, 2 definition, 5:4 level
    //                        r   1, 2, 5:4 from the last accepted go, 8 busy,
    //                            9 released, 10 error
    // 10 result low word     r
    // 14 result high word    r
    // 18 filter settings     r   14:8 input 1, 6:0 input 0
    // 1c average of input 0  r
    // 20 average of input 1  r
    // 24 resource info       r   fixed resource identifier
    // Other words read zero and drop writes; addresses alias every
    // 256 bytes because only bits 7:2 are decoded.
    // A request takes two edges after its control write: one arms
    // busy, the next executes and raises released. A go while busy
    // is dropped, so software must poll released between requests.

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] reg_idx(input logic [31:0] addr);
        reg_idx = addr[7:2];
    endfunction

    function automatic logic [AIF_SAMPLE_W-1:0] mix(
        input logic [6:0]              pct,
        input logic [AIF_SAMPLE_W-1:0] smp,
        input logic [AIF_SAMPLE_W-1:0] avg
    );
        logic [23:0] acc;
        // Truncation: a low setting can settle a few counts under the input
        acc = 24'(pct) * 24'(smp)
            + 24'(AIF_PCT_FULL - pct) * 24'(avg);
        mix = AIF_SAMPLE_W'(acc / 24'(AIF_PCT_FULL));
    endfunction

    aif_state_type q;
    aif_state_type d;
    logic          addr_ok;
    logic          wr_ok;
    logic [5:0]    aidx;
    logic [7:0]    val;
    logic [6:0]    pct;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d       = q;
        addr_ok = i_hsel && i_hready && (i_htrans == AIF_HTRANS_NSEQ);
        aidx    = reg_idx(i_haddr);
        val     = q.buffer[7:0];
        pct     = val[6:0];
        wr_ok   = 1'b0;

        // ------------------------------------------------------------
        // Bus write data phase
        // ------------------------------------------------------------
        d.wr_pend = addr_ok && i_hwrite;
        d.wr_idx  = aidx;
        if (q.wr_pend)
        begin
            unique case (q.wr_idx)
                AIF_IDX_RID:    d.resource_identifier    = i_hwdata[11:0];
                AIF_IDX_OFFSET: d.off    = i_hwdata[14:0];
                AIF_IDX_BUFFER: d.buffer = i_hwdata;
                AIF_IDX_CTRL:
                begin
                    // Go while busy is dropped so released never races
                    if (i_hwdata[AIF_CTRL_GO] && !q.busy)
                    begin
                        d.dir_wr   = i_hwdata[AIF_CTRL_WRITE];
                        d.def_rd   = i_hwdata[AIF_CTRL_DEF];
                        d.lvl      = i_hwdata[AIF_CTRL_LVL_LO +: 2];
                        d.busy     = 1'b1;
                        d.released = 1'b0;
                        d.err      = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Request execution
        // ------------------------------------------------------------
        if (q.busy)
        begin
            d.busy     = 1'b0;
            d.released = 1'b1;
            d.err      = 1'b0;
            if (q.resource_identifier != AIF_RID)
                d.err = 1'b1;
            else if (q.def_rd && !q.dir_wr)
            begin
                d.result = 64'h0;
                unique case (q.off)
                    AIF_DEF_LABEL:   d.result = {AIF_LABEL_HI, AIF_LABEL_LO};
                    AIF_DEF_SIZE:
                        d.result[7:0] = AIF_DATA_SIZE;
                    AIF_DEF_RDLVL:
                        d.result[7:0] = AIF_RD_LEVEL;
                    AIF_DEF_WRLVL:
                        d.result[7:0] = AIF_WR_LEVEL;
                    AIF_DEF_OVERRUN:
                        d.result[7:0] = AIF_TIME_OVERRUN;
                    AIF_DEF_TYPE:
                        d.result[7:0] = AIF_DATA_TYPE;
                    default:         d.err = 1'b1;
                endcase
            end
            else if (q.off >= AIF_NUM_FUNC)
                d.err = 1'b1;
            else if (!q.dir_wr)
                d.result = {57'h0, q.filt[q.off[0]]};
            else
            begin
                // Reserved bytes 1 to 3 are not checked
                wr_ok = (8'(q.lvl) >= AIF_WR_LEVEL)
                     && (val >= 8'(AIF_PCT_MIN))
                     && (val <= 8'(AIF_PCT_FULL));
                d.err = !wr_ok;
                if (wr_ok)
                    d.filt[q.off[0]] = pct;
            end
        end

        // ------------------------------------------------------------
        // Filtering; first sample after reset seeds the average
        // ------------------------------------------------------------
        for (int i = 0; i < AIF_NUM_IO; i++)
        begin
            if (i_ain[i].valid)
            begin
                d.primed[i] = 1'b1;
                if (!q.primed[i] || q.filt[i] == AIF_PCT_FULL)
                    d.avg[i] = i_ain[i].data;
                else
                    d.avg[i] = mix(q.filt[i], i_ain[i].data,
                                   q.avg[i]);
            end
        end

        // ------------------------------------------------------------
        // Read data registered at the address phase
        // ------------------------------------------------------------
        // No wait states: a read whose address meets the data phase of
        // a write to the same word still returns the old value
        if (addr_ok && !i_hwrite)
        begin
            unique case (aidx)
                AIF_IDX_RID:    d.rdata = {20'h0, q.resource_identifier};
                AIF_IDX_OFFSET: d.rdata = {17'h0, q.off};
                AIF_IDX_BUFFER: d.rdata = q.buffer;
                AIF_IDX_CTRL:   d.rdata = {21'h0, q.err, q.released, q.busy,
                                           2'h0, q.lvl, 1'b0, q.def_rd,
                                           q.dir_wr, 1'b0};
                AIF_IDX_RES_LO: d.rdata = q.result[31:0];
                AIF_IDX_RES_HI: d.rdata = q.result[63:32];
                AIF_IDX_FILT:   d.rdata = {17'h0, q.filt[1], 1'b0, q.filt[0]};
                AIF_IDX_AVG0:   d.rdata = {16'h0, q.avg[0]};
                AIF_IDX_AVG1:   d.rdata = {16'h0, q.avg[1]};
                AIF_IDX_INFO:   d.rdata = {20'h0, AIF_RID};
                default:        d.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q      <= '0;
            // Filters wake up as pass-through
            q.filt <= {AIF_NUM_IO{AIF_PCT_FULL}};
        end
        else
            q <= d;
    end

    // Zero wait states: every transfer completes in one data phase
    assign o_hrdata    = q.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = AIF_HRESP_OKAY;
    assign o_avg       = q.avg;
    assign o_released  = q.released;

endmodule
`default_nettype wire

// *** verilog/aif_pkg.sv ***
// Constants and types for the analog input filter configuration block
`default_nettype none
package aif_pkg;
    // ----------------------------------------------------------------
    // Resource definition
    // ----------------------------------------------------------------
    localparam logic [11:0] AIF_RID          = 12'h201;
    localparam logic [7:0]  AIF_DATA_SIZE    = 8'h04;
    localparam logic [7:0]  AIF_RD_LEVEL     = 8'h00;
    localparam logic [7:0]  AIF_WR_LEVEL     = 8'h02;
    localparam logic [7:0]  AIF_TIME_OVERRUN = 8'h5a;
    localparam logic [7:0]  AIF_DATA_TYPE    = 8'h14;
    localparam logic [31:0] AIF_LABEL_LO     = 32'h414e414d;
    localparam logic [31:0] AIF_LABEL_HI     = 32'h4f494547;
    localparam logic [14:0] AIF_DEF_LABEL    = 15'h0000;
    localparam logic [14:0] AIF_DEF_SIZE     = 15'h0001;
    localparam logic [14:0] AIF_DEF_RDLVL    = 15'h0002;
    localparam logic [14:0] AIF_DEF_WRLVL    = 15'h0003;
    localparam logic [14:0] AIF_DEF_OVERRUN  = 15'h0004;
    localparam logic [14:0] AIF_DEF_TYPE     = 15'h0005;
    // ----------------------------------------------------------------
    // Management functions and filter values
    // ----------------------------------------------------------------
    localparam int          AIF_NUM_IO       = 2;
    localparam logic [14:0] AIF_NUM_FUNC     = 15'h0002;
    localparam logic [6:0]  AIF_PCT_MIN      = 7'h01;
    localparam logic [6:0]  AIF_PCT_FULL     = 7'h64;
    localparam int          AIF_SAMPLE_W     = 16;
    // ----------------------------------------------------------------
    // Register map (word indices, address bits 7:2) and fields
    // ----------------------------------------------------------------
    localparam logic [5:0]  AIF_IDX_RID      = 6'h00;
    localparam logic [5:0]  AIF_IDX_OFFSET   = 6'h01;
    localparam logic [5:0]  AIF_IDX_BUFFER   = 6'h02;
    localparam logic [5:0]  AIF_IDX_CTRL     = 6'h03;
    localparam logic [5:0]  AIF_IDX_RES_LO   = 6'h04;
    localparam logic [5:0]  AIF_IDX_RES_HI   = 6'h05;
    localparam logic [5:0]  AIF_IDX_FILT     = 6'h06;
    localparam logic [5:0]  AIF_IDX_AVG0     = 6'h07;
    localparam logic [5:0]  AIF_IDX_AVG1     = 6'h08;
    localparam logic [5:0]  AIF_IDX_INFO     = 6'h09;
    localparam int          AIF_CTRL_GO      = 0;
    localparam int          AIF_CTRL_WRITE   = 1;
    localparam int          AIF_CTRL_DEF     = 2;
    localparam int          AIF_CTRL_LVL_LO  = 4;
    localparam int          AIF_CTRL_BUSY    = 8;
    localparam int          AIF_CTRL_REL     = 9;
    localparam int          AIF_CTRL_ERR     = 10;
    localparam logic [1:0]  AIF_HTRANS_NSEQ  = 2'h2;
    localparam logic        AIF_HRESP_OKAY   = 1'h0;

    typedef struct packed {
        logic                    valid;
        logic [AIF_SAMPLE_W-1:0] data;
    } aif_sample_type;

    typedef struct packed {
        logic [11:0]                           resource_identifier;
        logic [14:0]                           off;
        logic [31:0]                           buffer;
        logic [1:0]                            lvl;
        logic                                  dir_wr;
        logic                                  def_rd;
        logic                                  busy;
        logic                                  released;
        logic                                  err;
        logic [63:0]                           result;
        logic [AIF_NUM_IO-1:0][6:0]            filt;
        logic [AIF_NUM_IO-1:0][AIF_SAMPLE_W-1:0] avg;
        logic [AIF_NUM_IO-1:0]                 primed;
        logic                                  wr_pend;
        logic [5:0]                            wr_idx;
        logic [31:0]                           rdata;
    } aif_state_type;
endpackage
`default_nettype wire
